// File: accel_regs_defs.svh
`ifndef ACCEL_REGS_DEFS_SVH
`define ACCEL_REGS_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_READY_FLAGS 8'h00
`define ADDR_X_HIGH 8'h01
`define ADDR_X_LOW 8'h02
`define ADDR_Y_HIGH 8'h03
`define ADDR_Y_LOW 8'h04
`define ADDR_Z_HIGH 8'h05
`define ADDR_Z_LOW 8'h06

// ****************************************
// Field positions in the flag register
// ****************************************
`define BIT_X_READY 0
`define BIT_Y_READY 1
`define BIT_Z_READY 2
`define BIT_ALL_READY 3

// ****************************************
// Reset values
// ****************************************
`define RESET_FLAGS 4'h0
`define RESET_SAMPLE 14'h0000
`define RESET_BYTE 8'h00

`endif

// File: accel_regs_pkg.sv
`default_nettype none

package accel_regs_pkg;

  // Three-axis sample set
  typedef struct packed {
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
  } sample_set_t;

  // Per-axis strobes, x in bit 0
  typedef logic [2:0] axis_bits_t;

  // Register read request
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } read_req_t;

  // Holding state of a pending low byte
  typedef enum logic [1:0] {
    HOLD_NONE,
    HOLD_X,
    HOLD_Y,
    HOLD_Z
  } hold_axis_t;

endpackage

`default_nettype wire

// File: accel_status_and_sample_regs.sv
// Overview of operation
// - All-axes ready flag sets once every axis has a fresh sample.
// - All-axes ready flag clears after all three high bytes are read.
// - Z ready sets on new Z sample, clears on Z high read.
// - Y ready sets on new Y sample, clears on Y high read.
// - X ready sets on new X sample, clears on X high read.
// - All four ready flags read zero after reset.
// - Ready flags live at address zero, showing live status.
// - Samples are 14-bit two's-complement values.
// - Sample bytes at 0x01..0x06: X high, X low, Y, Z.
// - Low byte valid only right after its high byte read.
// - High then low read yields bytes of one sample.
// - High holds bits 13..6; low holds bits 5..0 in 7..2.
// - Enable pin low resets all register contents.
`include "accel_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module accel_status_and_sample_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Enable pin, low clears contents
  input wire logic enable,
  // Sample producer
  input wire accel_regs_pkg::axis_bits_t sample_strobe,
  input wire accel_regs_pkg::sample_set_t sample_in,
  // Register read port
  input wire accel_regs_pkg::read_req_t read_req,
  output logic [7:0] read_data,
  output logic read_valid,
  // Live flag view
  output logic [3:0] ready_flags
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    accel_regs_pkg::sample_set_t samples;
    logic [2:0] axis_ready;
    logic all_ready;
    logic [2:0] high_read_seen;
    accel_regs_pkg::hold_axis_t hold_axis;
    logic [7:0] held_low;
    logic [7:0] rdata;
    logic rvalid;
  } state_t;

  state_t state;
  state_t next_state;

  // High byte of a sample
  function automatic logic [7:0] high_byte(input logic [13:0] s);
    high_byte = s[13:6];
  endfunction

  // Low byte of a sample, two zero pad bits
  function automatic logic [7:0] low_byte(input logic [13:0] s);
    low_byte = {s[5:0], 2'b00};
  endfunction

  logic [2:0] high_hit;
  logic [2:0] any_fresh;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'b0;
    high_hit = 3'b000;
    if (read_req.valid)
    begin
      next_state.rvalid = 1'b1;
      next_state.hold_axis = accel_regs_pkg::HOLD_NONE;
      next_state.rdata = `RESET_BYTE;
      // Address decode, unmapped reads answer zero
      if (read_req.addr == `ADDR_READY_FLAGS)
      begin
        next_state.rdata = {4'h0, state.all_ready, state.axis_ready};
      end
      else if (read_req.addr == `ADDR_X_HIGH)
      begin
        high_hit[0] = 1'b1;
        next_state.rdata = high_byte(state.samples.x);
        next_state.held_low = low_byte(state.samples.x);
        next_state.hold_axis = accel_regs_pkg::HOLD_X;
      end
      else if (read_req.addr == `ADDR_Y_HIGH)
      begin
        high_hit[1] = 1'b1;
        next_state.rdata = high_byte(state.samples.y);
        next_state.held_low = low_byte(state.samples.y);
        next_state.hold_axis = accel_regs_pkg::HOLD_Y;
      end
      else if (read_req.addr == `ADDR_Z_HIGH)
      begin
        high_hit[2] = 1'b1;
        next_state.rdata = high_byte(state.samples.z);
        next_state.held_low = low_byte(state.samples.z);
        next_state.hold_axis = accel_regs_pkg::HOLD_Z;
      end
      else if (read_req.addr == `ADDR_X_LOW)
      begin
        if (state.hold_axis == accel_regs_pkg::HOLD_X)
          next_state.rdata = state.held_low;
      end
      else if (read_req.addr == `ADDR_Y_LOW)
      begin
        if (state.hold_axis == accel_regs_pkg::HOLD_Y)
          next_state.rdata = state.held_low;
      end
      else if (read_req.addr == `ADDR_Z_LOW)
      begin
        if (state.hold_axis == accel_regs_pkg::HOLD_Z)
          next_state.rdata = state.held_low;
      end
    end
    // New samples land; set wins over a same-cycle clear
    if (sample_strobe[0])
      next_state.samples.x = sample_in.x;
    if (sample_strobe[1])
      next_state.samples.y = sample_in.y;
    if (sample_strobe[2])
      next_state.samples.z = sample_in.z;
    next_state.axis_ready = (state.axis_ready & ~high_hit) | sample_strobe;
    // Axis flags as they stand after this cycle, same-cycle high reads counted
    any_fresh = next_state.axis_ready;
    // High reads gathered since the all-axes flag last set
    next_state.high_read_seen = state.high_read_seen | high_hit;
    if (state.all_ready && (next_state.high_read_seen == 3'b111))
    begin
      next_state.all_ready = 1'b0;
      next_state.high_read_seen = 3'b000;
    end
    if (any_fresh == 3'b111 && sample_strobe != 3'b000)
    begin
      next_state.all_ready = 1'b1;
      next_state.high_read_seen = high_hit;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!reset_n || !enable)
    begin
      state <= '0;
      {state.all_ready, state.axis_ready} <= `RESET_FLAGS;
      state.samples <= {3{`RESET_SAMPLE}};
      state.hold_axis <= accel_regs_pkg::HOLD_NONE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs
  assign read_data = state.rdata;
  assign read_valid = state.rvalid;
  assign ready_flags = {state.all_ready, state.axis_ready};

  // ****************************************
  // Assertions
  // ****************************************
  a_flags_after_reset: assert property (@(posedge clk)
    !reset_n |=> ready_flags == 4'h0)
    else $error("flags not clear after reset");

  a_x_ready_set: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    sample_strobe[0] |=> ready_flags[0])
    else $error("x ready not set");

  a_y_ready_set: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    sample_strobe[1] |=> ready_flags[1])
    else $error("y ready not set");

  a_z_ready_clear: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Z_HIGH && !sample_strobe[2]) |=> !ready_flags[2])
    else $error("z ready not cleared");

  a_all_ready_set: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (sample_strobe == 3'b111) |=> ready_flags[3])
    else $error("all ready not set");

  a_read_one_cycle: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    read_req.valid |=> read_valid ##1 !read_valid || $past(read_req.valid))
    else $error("read answer timing wrong");

  a_x_high_data: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_X_HIGH && !sample_strobe[0])
    |=> read_data == state.samples.x[13:6])
    else $error("x high byte wrong");

  a_low_pad_zero: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_valid && $past(read_req.addr) == `ADDR_Y_LOW) |-> read_data[1:0] == 2'b00)
    else $error("low byte pad not zero");

  a_low_paired: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_X_HIGH && !sample_strobe[0])
    ##1 !read_req.valid ##1 (read_req.valid && read_req.addr == `ADDR_X_LOW)
    |=> read_data == {$past(state.samples.x[5:0], 3), 2'b00})
    else $error("low byte not from held sample");

  a_random_low_zero: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Z_LOW
     && state.hold_axis != accel_regs_pkg::HOLD_Z) |=> read_data == 8'h00)
    else $error("random low read not zero");

  a_hold_dropped: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_X_LOW
     && state.hold_axis != accel_regs_pkg::HOLD_X) |=> read_data == 8'h00)
    else $error("x low read without hold not zero");

  // ****************************************
  // Flag, enable and reset checks
  // ****************************************
  a_x_ready_clear: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_X_HIGH && !sample_strobe[0]) |=> !ready_flags[0])
    else $error("x ready not cleared");

  a_y_ready_clear: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Y_HIGH && !sample_strobe[1]) |=> !ready_flags[1])
    else $error("y ready not cleared");

  a_z_ready_set: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    sample_strobe[2] |=> ready_flags[2])
    else $error("z ready not set");

  a_all_ready_hold: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (ready_flags[3] && !(read_req.valid && (read_req.addr == `ADDR_X_HIGH
     || read_req.addr == `ADDR_Y_HIGH || read_req.addr == `ADDR_Z_HIGH))) |=> ready_flags[3])
    else $error("all ready dropped without a high read");

  a_enable_clears: assert property (@(posedge clk)
    !enable |=> ready_flags == 4'h0 && read_data == 8'h00 && !read_valid)
    else $error("enable low did not clear contents");

  a_reset_read_idle: assert property (@(posedge clk)
    !reset_n |=> read_data == 8'h00 && !read_valid)
    else $error("read port not idle after reset");

  // ****************************************
  // Read path checks
  // ****************************************
  a_status_view: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_READY_FLAGS) |=> read_data == {4'h0, $past(ready_flags)})
    else $error("status read does not show flags");

  a_y_high_data: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Y_HIGH && !sample_strobe[1])
    |=> read_data == state.samples.y[13:6])
    else $error("y high byte wrong");

  a_z_high_data: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Z_HIGH && !sample_strobe[2])
    |=> read_data == state.samples.z[13:6])
    else $error("z high byte wrong");

  a_unmapped_zero: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr > `ADDR_Z_LOW) |=> read_data == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_stable: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (reset_n && enable && !read_req.valid) |=> $stable(read_data))
    else $error("read data moved without a read");

  // ****************************************
  // Pairing checks
  // ****************************************
  a_y_low_paired: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Y_HIGH)
    ##1 !read_req.valid ##1 (read_req.valid && read_req.addr == `ADDR_Y_LOW)
    |=> read_data == {$past(state.samples.y[5:0], 3), 2'b00})
    else $error("y low byte not from held sample");

  a_z_low_paired: assert property (@(posedge clk) disable iff (!reset_n || !enable)
    (read_req.valid && read_req.addr == `ADDR_Z_HIGH)
    ##1 !read_req.valid ##1 (read_req.valid && read_req.addr == `ADDR_Z_LOW)
    |=> read_data == {$past(state.samples.z[5:0], 3), 2'b00})
    else $error("z low byte not from held sample");

  // ****************************************
  // Coverage
  // ****************************************
  c_all_ready: cover property (@(posedge clk) disable iff (!reset_n) ready_flags[3]);
  c_pair_read: cover property (@(posedge clk) disable iff (!reset_n)
    (read_req.valid && read_req.addr == `ADDR_Y_HIGH)
    ##2 (read_req.valid && read_req.addr == `ADDR_Y_LOW));
  c_all_cleared: cover property (@(posedge clk) disable iff (!reset_n)
    ready_flags[3] ##1 !ready_flags[3]);
  c_enable_clear: cover property (@(posedge clk) disable iff (!reset_n)
    (ready_flags != 4'h0) ##1 !enable);
  c_hold_over_sample: cover property (@(posedge clk) disable iff (!reset_n)
    (read_req.valid && read_req.addr == `ADDR_X_HIGH) ##[1:3] sample_strobe[0]
    ##[1:3] (read_req.valid && read_req.addr == `ADDR_X_LOW));

endmodule

`default_nettype wire

// File: mcu_reader.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Serial bus master stand-in, byte reads
// ****************************************
module mcu_reader
(
  // Clock
  input wire logic clk,
  // Register read port
  output var accel_regs_pkg::read_req_t read_req,
  input wire logic [7:0] read_data,
  input wire logic read_valid
);
  // Idle port at time zero
  initial read_req = '0;

  // One request cycle, answer taken one cycle after the request edge
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    @(posedge clk);
    read_req <= '{valid: 1'b1, addr: addr};
    @(posedge clk);
    read_req <= '{valid: 1'b0, addr: ~addr}; // Released address no longer shows the last one
    #1;
    ok = read_valid;
    data = read_data;
  endtask
endmodule

`default_nettype wire

// File: testbench.sv
`include "accel_regs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clk;
  logic reset_n;
  logic enable;
  accel_regs_pkg::axis_bits_t sample_strobe;
  accel_regs_pkg::sample_set_t sample_in;
  accel_regs_pkg::sample_set_t s;
  accel_regs_pkg::sample_set_t s2;
  accel_regs_pkg::read_req_t read_req;
  logic [7:0] read_data;
  logic read_valid;
  logic [3:0] ready_flags;
  logic [7:0] got;
  logic ok;
  logic [13:0] cur [3];
  int n_fail;
  int checks;
  int cycles;

  // ****************************************
  // Design and master model
  // ****************************************
  accel_status_and_sample_regs u_dut (.clk(clk), .reset_n(reset_n), .enable(enable),
    .sample_strobe(sample_strobe), .sample_in(sample_in), .read_req(read_req),
    .read_data(read_data), .read_valid(read_valid), .ready_flags(ready_flags));
  mcu_reader u_mcu (.clk(clk), .read_req(read_req), .read_data(read_data),
    .read_valid(read_valid));

  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Expectations and helpers
  // ****************************************
  function automatic logic [7:0] high_of(input logic [13:0] v);
    return v[13:6];
  endfunction
  function automatic logic [7:0] low_of(input logic [13:0] v);
    return {v[5:0], 2'b00};
  endfunction

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One-cycle sample pulse on chosen axes
  task automatic strobe(input accel_regs_pkg::axis_bits_t bits,
                        input accel_regs_pkg::sample_set_t v);
    @(posedge clk);
    sample_strobe <= bits;
    sample_in <= v;
    @(posedge clk);
    sample_strobe <= '0;
    sample_in <= ~v; // Bus no longer shows the sample
    #1;
  endtask

  // Read one byte and compare
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    u_mcu.read_byte(a, got, ok);
    check({7'h00, ok}, 8'h01);
    check(got, e);
  endtask

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      $display("mismatch at %0t: run did not finish", $time);
      give_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset_n = 1'b0;
    enable = 1'b1;
    sample_strobe = '0;
    sample_in = '0;
    n_fail = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(32'h7B9D7BF3));
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check({4'h0, ready_flags}, 8'h00);
    rd(`ADDR_READY_FLAGS, 8'h00);
    for (int i = 0; i < 24; i++)
    begin
      s.x = (i == 0) ? 14'h1FFF : 14'($urandom);
      s.y = (i == 0) ? 14'h2000 : 14'($urandom);
      s.z = (i == 0) ? 14'h3FFF : 14'($urandom);
      cur[0] = s.x;
      cur[1] = s.y;
      cur[2] = s.z;
      strobe(3'b001, s);
      strobe(3'b010, s);
      check({4'h0, ready_flags}, 8'h03);
      strobe(3'b100, s);
      check({4'h0, ready_flags}, 8'h0F);
      rd(`ADDR_READY_FLAGS, 8'h0F);
      for (int a = 0; a < 3; a++)
      begin
        rd(8'(1 + 2 * a), high_of(cur[a]));
        if (i % 2 == 0)
          check({4'h0, ready_flags}, (a == 2) ? 8'h00 : 8'((4'hF << (a + 1)) & 4'hF));
        else
        begin
          s2.x = 14'($urandom);
          s2.y = 14'($urandom);
          s2.z = 14'($urandom);
          strobe(3'(1 << a), s2);
        end
        rd(8'(2 + 2 * a), low_of(cur[a]));
      end
      rd(8'(7 + $urandom % 249), 8'h00);
      rd(8'(2 + 2 * (i % 3)), 8'h00);
      @(posedge clk);
      enable <= 1'b0;
      @(posedge clk);
      enable <= 1'b1;
      #1;
      check({4'h0, ready_flags}, 8'h00);
      rd(`ADDR_X_HIGH, 8'h00);
    end
    give_verdict();
  end
endmodule

`default_nettype wire
